// File: logic/pmsr_energy_acc.sv
// One wrapping watt-hour energy counter with its own wrap counter.
`timescale 1ns/100ps
module pmsr_energy_acc (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] incAmount,
    output logic [pmsr_pkg::PMSR_ENERGY_W-1:0] count,
    output logic [pmsr_pkg::PMSR_WRAP_W-1:0] wraps
);
    import pmsr_pkg::*;

    logic [PMSR_ENERGY_W-1:0] count_q;
    logic [PMSR_ENERGY_W-1:0] count_d;
    logic [PMSR_WRAP_W-1:0] wraps_q;
    logic [PMSR_WRAP_W-1:0] wraps_d;
    logic [PMSR_ENERGY_W:0] sum;

    always_comb begin
        sum = {1'b0, count_q} + {{(PMSR_ENERGY_W - 1){1'b0}}, incAmount};
        count_d = sum[PMSR_ENERGY_W-1:0];
        wraps_d = wraps_q;
        if (sum[PMSR_ENERGY_W]) begin
            wraps_d = wraps_q + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_q <= 32'h00000000;
            wraps_q <= 8'h00;
        end else begin
            count_q <= count_d;
            wraps_q <= wraps_d;
        end
    end

    assign count = count_q;
    assign wraps = wraps_q;
endmodule

// File: logic/pmsr_pkg.sv
// Constants shared by the power meter status readout logic.
package pmsr_pkg;
    localparam int PMSR_PHASES = 3;
    localparam int PMSR_ENERGY_W = 32;
    localparam int PMSR_WRAP_W = 8;
    localparam int PMSR_FLAG_W = 16;

    // Measurand identifiers; the bus byte address is four times the ID.
    localparam logic [5:0] ID_E_CONS = 6'h01;
    localparam logic [5:0] ID_E_PROD = 6'h02;
    localparam logic [5:0] ID_E_L1_CONS = 6'h03;
    localparam logic [5:0] ID_P_TOTAL = 6'h09;
    localparam logic [5:0] ID_FREQ = 6'h0c;
    localparam logic [5:0] ID_TEMP = 6'h0e;
    localparam logic [5:0] ID_P_L1 = 6'h0f;
    localparam logic [5:0] ID_V_L1 = 6'h12;
    localparam logic [5:0] ID_I_L1 = 6'h13;
    localparam logic [5:0] ID_PF_L1 = 6'h14;
    localparam logic [5:0] ID_PHASE_STEP = 6'h08;
    localparam logic [5:0] ID_OVF_CONS = 6'h27;
    localparam logic [5:0] ID_OVF_PROD = 6'h28;
    localparam logic [5:0] ID_FLAGS = 6'h29;

    // Configuration, command and data-set count words outside the measurand space.
    localparam logic [8:0] ADR_V_LOW = 9'h100;
    localparam logic [8:0] ADR_V_HIGH = 9'h104;
    localparam logic [8:0] ADR_I_HIGH = 9'h108;
    localparam logic [8:0] ADR_PF_LOW = 9'h10c;
    localparam logic [8:0] ADR_T_HIGH = 9'h110;
    localparam logic [8:0] ADR_F_LOW = 9'h114;
    localparam logic [8:0] ADR_F_HIGH = 9'h118;
    localparam logic [8:0] ADR_CMD = 9'h180;
    localparam logic [8:0] ADR_DS_COUNT = 9'h184;

    localparam logic [7:0] CMD_ACK_FLAGS = 8'h04;

    // Flag positions in the 16-bit word {byte 0, byte 1}.
    localparam int FLAG_RESET = 0;
    localparam int FLAG_I1_HIGH = 1;
    localparam int FLAG_PF1_LOW = 4;
    localparam int FLAG_V1_LOW = 7;
    localparam int FLAG_V2_LOW = 8;
    localparam int FLAG_V1_HIGH = 10;
    localparam int FLAG_T_HIGH = 13;
    localparam int FLAG_F_LOW = 14;
    localparam int FLAG_F_HIGH = 15;

    // Limit reset values: limits start wide open.
    localparam logic [31:0] RST_V_LOW = 32'h00000000;
    localparam logic [31:0] RST_V_HIGH = 32'hffffffff;
    localparam logic [31:0] RST_I_HIGH = 32'hffffffff;
    localparam logic [7:0] RST_PF_LOW = 8'h80;
    localparam logic [15:0] RST_T_HIGH = 16'h7fff;
    localparam logic [15:0] RST_F_LOW = 16'h0000;
    localparam logic [15:0] RST_F_HIGH = 16'hffff;

    localparam logic [31:0] INT32_MAX = 32'h7fffffff;
    localparam logic [31:0] INT32_MIN = 32'h80000000;
endpackage

// File: logic/pmsr_top.sv
// Power meter readout: measurands by ID, limit flags, energy counters.
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/100ps
// Overview of operation
// - Thresholds come from software-written limit registers.
// - Flags update only on data-set counter advance.
// - Set flags stay until command acknowledges them.
// - Acknowledge also clears the limit lamps.
// - Flag word reads high byte before low.
// - Byte0 bits0-4: V2/V3 low, V1-V3 high.
// - Byte0 bits5-7: temp high, freq low/high.
// - Reset flag set by reset, cleared by 0x04.
// - Byte1 bits1-3: phase currents above maximum.
// - Byte1 bits4-6 power factor low, bit7 V1.
// - Each measurand read at its own ID.
// - Energy counters unsigned 32-bit watt-hours, wrapping.
// - IDs 39/40 count consumer/producer energy wraps.
// - Overflow word: L1,L2,L3 bytes, top byte zero.
// - Total power saturates instead of wrapping.
module pmsr_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic dataSetAdvance,
    input wire logic [95:0] phaseVoltage,
    input wire logic [95:0] phaseCurrent,
    input wire logic [95:0] phasePower,
    input wire logic [23:0] phasePowerFactor,
    input wire logic [15:0] frequency,
    input wire logic [15:0] temperature,
    input wire logic [5:0] energyTick,
    output logic [15:0] limitLamps
);
    import pmsr_pkg::*;

    // Byte-lane merge used by every writable limit register.
    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] din,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = din[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Bit index of the voltage-low flag of one phase.
    function automatic int voltLowBit(input int p);
        return (p == 0) ? FLAG_V1_LOW : FLAG_V2_LOW + p - 1;
    endfunction

    // ---------------- Bus access decode ----------------
    logic busReq;
    logic busWrite;
    assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign busWrite = busReq & wb_we_i;

    logic ackCmd;
    assign ackCmd = busWrite && wb_adr_i == ADR_CMD && wb_sel_i[0]
                    && wb_dat_i[7:0] == CMD_ACK_FLAGS;

    // ---------------- Limit registers ----------------
    logic [31:0] vLow_q, vLow_d, vHigh_q, vHigh_d, iHigh_q, iHigh_d;
    logic [7:0] pfLow_q, pfLow_d;
    logic [15:0] tHigh_q, tHigh_d, fLow_q, fLow_d, fHigh_q, fHigh_d;
    logic [31:0] tmp;

    always_comb begin
        vLow_d = vLow_q;
        vHigh_d = vHigh_q;
        iHigh_d = iHigh_q;
        pfLow_d = pfLow_q;
        tHigh_d = tHigh_q;
        fLow_d = fLow_q;
        fHigh_d = fHigh_q;
        tmp = 32'h00000000;
        if (busWrite) begin
            unique case (wb_adr_i)
                ADR_V_LOW: vLow_d = mergeBytes(vLow_q, wb_dat_i, wb_sel_i);
                ADR_V_HIGH: vHigh_d = mergeBytes(vHigh_q, wb_dat_i, wb_sel_i);
                ADR_I_HIGH: iHigh_d = mergeBytes(iHigh_q, wb_dat_i, wb_sel_i);
                ADR_PF_LOW: begin
                    tmp = mergeBytes({24'h000000, pfLow_q}, wb_dat_i,
                                     wb_sel_i);
                    pfLow_d = tmp[7:0];
                end
                ADR_T_HIGH: begin
                    tmp = mergeBytes({16'h0000, tHigh_q}, wb_dat_i, wb_sel_i);
                    tHigh_d = tmp[15:0];
                end
                ADR_F_LOW: begin
                    tmp = mergeBytes({16'h0000, fLow_q}, wb_dat_i, wb_sel_i);
                    fLow_d = tmp[15:0];
                end
                ADR_F_HIGH: begin
                    tmp = mergeBytes({16'h0000, fHigh_q}, wb_dat_i, wb_sel_i);
                    fHigh_d = tmp[15:0];
                end
                default: tmp = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vLow_q <= RST_V_LOW;
            vHigh_q <= RST_V_HIGH;
            iHigh_q <= RST_I_HIGH;
            pfLow_q <= RST_PF_LOW;
            tHigh_q <= RST_T_HIGH;
            fLow_q <= RST_F_LOW;
            fHigh_q <= RST_F_HIGH;
        end else begin
            vLow_q <= vLow_d;
            vHigh_q <= vHigh_d;
            iHigh_q <= iHigh_d;
            pfLow_q <= pfLow_d;
            tHigh_q <= tHigh_d;
            fLow_q <= fLow_d;
            fHigh_q <= fHigh_d;
        end
    end

    // ---------------- Limit comparison and sticky flags ----------------
    logic [PMSR_FLAG_W-1:0] violation;
    logic [PMSR_FLAG_W-1:0] flags_q, flags_d;

    always_comb begin
        violation = '0;
        for (int p = 0; p < PMSR_PHASES; p++) begin
            violation[voltLowBit(p)] =
                phaseVoltage[32*p +: 32] < vLow_q;
            violation[FLAG_V1_HIGH + p] =
                phaseVoltage[32*p +: 32] > vHigh_q;
            violation[FLAG_I1_HIGH + p] =
                phaseCurrent[32*p +: 32] > iHigh_q;
            violation[FLAG_PF1_LOW + p] = $signed(phasePowerFactor[8*p +: 8])
                < $signed(pfLow_q);
        end
        violation[FLAG_T_HIGH] = $signed(temperature) > $signed(tHigh_q);
        violation[FLAG_F_LOW] = frequency < fLow_q;
        violation[FLAG_F_HIGH] = frequency > fHigh_q;
        // A violation caught in the acknowledge cycle survives the clear.
        flags_d = ackCmd ? '0 : flags_q;
        if (dataSetAdvance) begin
            flags_d = flags_d | violation;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_q <= 16'h0001;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ---------------- Measurand snapshot and data-set counter -----------
    logic [95:0] volt_q, volt_d, curr_q, curr_d, pwr_q, pwr_d;
    logic [23:0] pf_q, pf_d;
    logic [15:0] freq_q, freq_d, temp_q, temp_d, dsCount_q, dsCount_d;
    logic [31:0] totalPwr_q, totalPwr_d;
    logic signed [33:0] pwrSum;

    always_comb begin
        pwrSum = 34'(signed'(phasePower[31:0]))
                 + 34'(signed'(phasePower[63:32]))
                 + 34'(signed'(phasePower[95:64]));
        volt_d = volt_q;
        curr_d = curr_q;
        pwr_d = pwr_q;
        pf_d = pf_q;
        freq_d = freq_q;
        temp_d = temp_q;
        dsCount_d = dsCount_q;
        totalPwr_d = totalPwr_q;
        if (dataSetAdvance) begin
            volt_d = phaseVoltage;
            curr_d = phaseCurrent;
            pwr_d = phasePower;
            pf_d = phasePowerFactor;
            freq_d = frequency;
            temp_d = temperature;
            dsCount_d = dsCount_q + 16'h0001;
            if (pwrSum > 34'(signed'(INT32_MAX))) begin
                totalPwr_d = INT32_MAX;
            end else if (pwrSum < -34'sh80000000) begin
                totalPwr_d = INT32_MIN;
            end else begin
                totalPwr_d = pwrSum[31:0];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            volt_q <= '0;
            curr_q <= '0;
            pwr_q <= '0;
            pf_q <= 24'h000000;
            freq_q <= 16'h0000;
            temp_q <= 16'h0000;
            dsCount_q <= 16'h0000;
            totalPwr_q <= 32'h00000000;
        end else begin
            volt_q <= volt_d;
            curr_q <= curr_d;
            pwr_q <= pwr_d;
            pf_q <= pf_d;
            freq_q <= freq_d;
            temp_q <= temp_d;
            dsCount_q <= dsCount_d;
            totalPwr_q <= totalPwr_d;
        end
    end

    // ---------------- Energy counters ----------------
    // Index 0/1 total consumer/producer, 2+2p / 3+2p phase p.
    logic [1:0] energyInc [8];
    logic [31:0] energy [8];
    logic [7:0] energyWraps [8];

    always_comb begin
        energyInc[0] = 2'(energyTick[0]) + 2'(energyTick[2])
                       + 2'(energyTick[4]);
        energyInc[1] = 2'(energyTick[1]) + 2'(energyTick[3])
                       + 2'(energyTick[5]);
        for (int k = 0; k < 6; k++) begin
            energyInc[k + 2] = {1'b0, energyTick[k]};
        end
    end

    for (genvar g = 0; g < 8; g++) begin : gEnergy
        pmsr_energy_acc uAcc (
            .clk(clk),
            .sys_rst(sys_rst),
            .incAmount(energyInc[g]),
            .count(energy[g]),
            .wraps(energyWraps[g])
        );
    end

    // ---------------- Read mux and bus answer ----------------
    logic [31:0] rdData;
    logic [31:0] dat_q, dat_d;
    logic ack_q, ack_d;
    logic [5:0] id;
    logic [5:0] rel;
    assign id = wb_adr_i[7:2];

    always_comb begin
        rdData = 32'h00000000;
        rel = id - ID_P_L1;
        if (wb_adr_i[8]) begin
            unique case (wb_adr_i)
                ADR_V_LOW: rdData = vLow_q;
                ADR_V_HIGH: rdData = vHigh_q;
                ADR_I_HIGH: rdData = iHigh_q;
                ADR_PF_LOW: rdData = {24'h000000, pfLow_q};
                ADR_T_HIGH: rdData = {16'h0000, tHigh_q};
                ADR_F_LOW: rdData = {16'h0000, fLow_q};
                ADR_F_HIGH: rdData = {16'h0000, fHigh_q};
                ADR_DS_COUNT: rdData = {16'h0000, dsCount_q};
                default: rdData = 32'h00000000;
            endcase
        end else if (id >= ID_E_CONS && id < ID_P_TOTAL) begin
            rdData = energy[3'(id - ID_E_CONS)];
        end else if (id >= ID_P_L1 && id < ID_OVF_CONS) begin
            for (int p = 0; p < PMSR_PHASES; p++) begin
                if (rel == 6'(p) * ID_PHASE_STEP) begin
                    rdData = pwr_q[32*p +: 32];
                end
                if (rel == 6'(p) * ID_PHASE_STEP + (ID_V_L1 - ID_P_L1)) begin
                    rdData = volt_q[32*p +: 32];
                end
                if (rel == 6'(p) * ID_PHASE_STEP + (ID_I_L1 - ID_P_L1)) begin
                    rdData = curr_q[32*p +: 32];
                end
                if (rel == 6'(p) * ID_PHASE_STEP + (ID_PF_L1 - ID_P_L1))
                begin
                    rdData = {{24{pf_q[8*p+7]}}, pf_q[8*p +: 8]};
                end
            end
        end else begin
            unique case (id)
                ID_P_TOTAL: rdData = totalPwr_q;
                ID_FREQ: rdData = {16'h0000, freq_q};
                ID_TEMP: rdData = {{16{temp_q[15]}}, temp_q};
                ID_OVF_CONS: rdData = {8'h00, energyWraps[2], energyWraps[4],
                                       energyWraps[6]};
                ID_OVF_PROD: rdData = {8'h00, energyWraps[3], energyWraps[5],
                                       energyWraps[7]};
                ID_FLAGS: rdData = {16'h0000, flags_q};
                default: rdData = 32'h00000000;
            endcase
        end
        ack_d = busReq;
        dat_d = busReq && !wb_we_i ? rdData : 32'h00000000;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign limitLamps = flags_q;
endmodule

// File: verification/pmsr_ctrl_model.sv
// Controller model that issues classic single Wishbone accesses.
`timescale 1ns/100ps
module pmsr_ctrl_model (
    input wire logic clk,
    input wire logic ackIn,
    input wire logic [31:0] datIn,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [8:0] adr,
    output logic [3:0] sel,
    output logic [31:0] datOut,
    output logic lostAck
);
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 9'h0;
        sel = 4'h0;
        datOut = 32'h0;
        lostAck = 1'b0;
    end
    // An ack still standing when a new request starts sets lostAck; the
    // wait itself is open, so only the bench watchdog ends a silent slave.
    task automatic access(input logic w, input logic [8:0] a,
            input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge clk);
        if (ackIn !== 1'b0) begin
            lostAck = 1'b1;
        end
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        datOut <= wd;
        do begin
            @(posedge clk);
        end while (ackIn !== 1'b1);
        rdat = datIn;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
endmodule

// File: verification/pmsr_tb_top.sv
// Testbench for limit flags, measurands and energy counters.
`timescale 1ns/100ps
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin nFail++; \
    $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module pmsr_tb_top;
    import pmsr_pkg::*;
    logic clk, rst, adv, cyc, stb, we, ack, lostAck;
    logic [8:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [95:0] volt, curr, pwr;
    logic [23:0] pf;
    logic [15:0] freq, temp, lamps;
    logic [5:0] tick;
    int nFail = 0;
    int totalChecks = 0;
    pmsr_top i_dut (.clk(clk), .sys_rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .dataSetAdvance(adv), .phaseVoltage(volt), .phaseCurrent(curr),
        .phasePower(pwr), .phasePowerFactor(pf), .frequency(freq),
        .temperature(temp), .energyTick(tick), .limitLamps(lamps));
    pmsr_ctrl_model i_ctrl (.clk(clk), .ackIn(ack), .datIn(rdat),
        .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
        .datOut(wdat), .lostAck(lostAck));
    function automatic logic [8:0] idA(input logic [5:0] id);
        return {1'b0, id, 2'b00};
    endfunction
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] r;
        i_ctrl.access(1'b1, a, d, r);
    endtask
    task automatic rdChk(input logic [8:0] a, input logic [31:0] e);
        logic [31:0] r;
        i_ctrl.access(1'b0, a, 32'h0, r);
        `CHK(r, e)
    endtask
    task automatic step();
        @(posedge clk);
        adv <= 1'b1;
        @(posedge clk);
        adv <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // Case 0 is nominal; case k pushes one input past the limit of flag k.
    task automatic setIn(input int k);
        logic [95:0] v, c;
        logic [23:0] p;
        logic [15:0] f, t;
        v = {3{32'h00038270}};
        c = {3{32'h000003e8}};
        p = {3{8'h5a}};
        f = 16'h1388;
        t = 16'h09c4;
        if (k == 0) begin
        end else if (k <= 3) c[32*(k-1) +: 32] = 32'h00001770;
        else if (k <= 6) p[8*(k-4) +: 8] = 8'h32;
        else if (k == 7) v[31:0] = 32'h000186a0;
        else if (k <= 9) v[32*(k-7) +: 32] = 32'h000186a0;
        else if (k <= 12) v[32*(k-10) +: 32] = 32'h0003f7a0;
        else if (k == 13) t = 16'h1770;
        else if (k == 14) f = 16'h12c0;
        else f = 16'h1450;
        @(posedge clk);
        volt <= v;
        curr <= c;
        pf <= p;
        freq <= f;
        temp <= t;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        wrap_up();
    end
    initial begin
        rst = 1'b1;
        adv = 1'b0;
        tick = 6'h00;
        volt = 96'h0;
        curr = 96'h0;
        pwr = 96'h0;
        pf = 24'h0;
        freq = 16'h0;
        temp = 16'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdChk(idA(ID_FLAGS), 32'h00000001);
        setIn(0);
        wr(ADR_V_LOW, 32'h00030d40);
        wr(ADR_V_HIGH, 32'h0003d090);
        wr(ADR_I_HIGH, 32'h00001388);
        wr(ADR_PF_LOW, 32'h00000050);
        wr(ADR_T_HIGH, 32'h00001388);
        wr(ADR_F_LOW, 32'h00001324);
        wr(ADR_F_HIGH, 32'h000013ec);
        step();
        rdChk(idA(ID_FLAGS), 32'h00000001);
        wr(ADR_CMD, 32'h00000005);
        rdChk(idA(ID_FLAGS), 32'h00000001);
        wr(ADR_CMD, {24'h0, CMD_ACK_FLAGS});
        rdChk(idA(ID_FLAGS), 32'h00000000);
        for (int k = 1; k < 16; k++) begin
            setIn(k);
            rdChk(idA(ID_FLAGS), 32'h00000000);
            step();
            rdChk(idA(ID_FLAGS), 32'h1 << k);
            `CHK(lamps, 16'h1 << k)
            setIn(0);
            step();
            rdChk(idA(ID_FLAGS), 32'h1 << k);
            wr(ADR_CMD, {24'h0, CMD_ACK_FLAGS});
            `CHK(lamps, 16'h0000)
        end
        @(posedge clk);
        tick <= 6'h15;
        repeat (2) @(posedge clk);
        tick <= 6'h02;
        @(posedge clk);
        tick <= 6'h00;
        step();
        rdChk(idA(ID_E_CONS), 32'h00000006);
        rdChk(idA(ID_E_PROD), 32'h00000001);
        for (int i = 3; i <= 8; i++) begin
            rdChk(idA(6'(i)), (i % 2 == 1) ? 32'h2 : {31'h0, i == 4});
        end
        rdChk(idA(ID_OVF_CONS), 32'h00000000);
        rdChk(idA(ID_OVF_PROD), 32'h00000000);
        pwr <= {3{32'h7fff0000}};
        step();
        rdChk(idA(ID_P_TOTAL), INT32_MAX);
        pwr <= {3{32'h80010000}};
        step();
        rdChk(idA(ID_P_TOTAL), INT32_MIN);
        pwr <= {32'hfffffe0c, 32'h000007d0, 32'h000003e8};
        step();
        rdChk(idA(ID_P_TOTAL), 32'h000009c4);
        rdChk(idA(ID_P_L1), 32'h000003e8);
        rdChk(idA(ID_V_L1), 32'h00038270);
        rdChk(idA(6'h24), 32'h0000005a);
        rdChk(ADR_V_HIGH, 32'h0003d090);
        rdChk(ADR_DS_COUNT, 32'h00000023);
        wr(idA(ID_FREQ), 32'h00000000);
        rdChk(idA(ID_FREQ), 32'h00001388);
        rdChk(idA(6'h0a), 32'h00000000);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdChk(idA(ID_FLAGS), 32'h00000001);
        `CHK(lamps, 16'h0001)
        rdChk(ADR_DS_COUNT, 32'h00000000);
        `CHK(lostAck, 1'b0)
        wrap_up();
    end
endmodule

// File: verification/pmsr_top_props.sv
// Checker for the readout's bus answers and its limit flag word.
`timescale 1ns/100ps
module pmsr_top_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic dataSetAdvance,
    input wire logic [15:0] limitLamps
);
    import pmsr_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic req;
    logic rd;
    logic cmdWr;
    logic quiet;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd = req && !wb_we_i;
    assign cmdWr = req && wb_we_i && wb_adr_i == ADR_CMD && wb_sel_i[0]
        && wb_dat_i[7:0] == CMD_ACK_FLAGS;
    assign quiet = !dataSetAdvance && !cmdWr;
    property p_ackOne;
        req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ackOne: assert property (p_ackOne) else $error("ack timing wrong");
    property p_datIdle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_datIdle: assert property (p_datIdle) else $error("data outside ack");
    property p_flagRead;
        rd && wb_adr_i == {1'b0, ID_FLAGS, 2'b00} && quiet
            |=> wb_dat_o == {16'h0, limitLamps};
    endproperty
    a_flagRead: assert property (p_flagRead)
        else $error("flag word read wrong");
    property p_noChange;
        quiet |=> $stable(limitLamps);
    endproperty
    a_noChange: assert property (p_noChange)
        else $error("flags moved without advance");
    property p_sticky;
        !cmdWr |=> (limitLamps & $past(limitLamps)) == $past(limitLamps);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_ackClear;
        cmdWr && !dataSetAdvance |=> limitLamps == 16'h0;
    endproperty
    a_ackClear: assert property (p_ackClear)
        else $error("lamps not cleared");
    property p_resetBit;
        !limitLamps[0] |=> !limitLamps[0];
    endproperty
    a_resetBit: assert property (p_resetBit)
        else $error("reset flag rose");
    property p_ovfTop;
        rd && wb_adr_i[8:2] inside {7'h27, 7'h28} |=> wb_dat_o[31:24] == 8'h0;
    endproperty
    a_ovfTop: assert property (p_ovfTop)
        else $error("overflow top byte");
    property p_gapId;
        rd && wb_adr_i == 9'h028 |=> wb_dat_o == 32'h0;
    endproperty
    a_gapId: assert property (p_gapId) else $error("unused id");
    c_ack: cover property (cmdWr);
    c_flagRead: cover property (rd && wb_adr_i == {1'b0, ID_FLAGS, 2'b00});
    c_flagSet: cover property (dataSetAdvance ##1 limitLamps != 16'h0);
endmodule
bind pmsr_top pmsr_top_props i_props (.clk(clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dataSetAdvance(dataSetAdvance), .limitLamps(limitLamps));
